// ---- design/coc_top.sv ----
// Purpose: condition the controller outputs (action, fixed values, time proportioning, limits)
// Assumes: one clock, all inputs synchronous, PID and program sequencing done upstream
// Notes: reset value beats error value; reset values skip the rate limiter, error values pass through it
// Function
// RULE_01 - reverse action raises demand as measured value drops below setpoint
// RULE_02 - direct action raises demand as measured value rises above setpoint
// RULE_03 - action direction writes refused during auto tuning
// RULE_04 - in reset each output holds its reset value, 0.0 to 100.0 percent
// RULE_05 - on-off control: reset value 50 percent or more full on, else off
// RULE_06 - reset value applies whether or not an input error exists
// RULE_07 - input error outside reset drives each output at its error value
// RULE_08 - on-off control: error value 50 percent or more full on, else off
// RULE_09 - error during reset still outputs the reset value
// RULE_10 - cycle time 1 to 120 s, default 30 s relay, 3 s SSR
// RULE_11 - cycle time writes refused during auto tuning or ramp
// RULE_12 - second output mirrors first; default direct single-loop, reverse two-loop
// RULE_13 - optional ten-segment linearizer for voltage or current inputs, off by default
// RULE_14 - breakpoints must increase; first non-increasing point and later ones ignored
// RULE_15 - outside the valid points extrapolate with first or last segment slope
// RULE_16 - per-output rate limit off or 0.1 to 100.0 percent per second
// RULE_17 - setpoint limits lie inside measuring range, low below high, default range
// RULE_18 - setpoint beyond limits replaced by violated limit and flagged
// RULE_19 - low and high compensation counts per output; zero means factory calibration
// RULE_20 - compensation editable only with keys unlocked and all channels in reset
// RULE_21 - compensation screen entered after enter and group held three seconds
// RULE_22 - time-proportioned output on for percentage fraction of each cycle
// RULE_23 - rate limiter caps change per second both rising and falling
`timescale 1ns/100ps
module coc_top #(
   parameter int CYC_PER_MS = coc_pkg::CYC_PER_MS_DEF
) (
   input wire logic CLK_SYS,
   input wire logic RESET_N,
   input wire logic TWO_OUT,
   input wire logic TWO_LOOP,
   input wire logic [1:0] RELAY_OUT,
   input wire logic AUTO_TUNING,
   input wire logic RAMP_ACTIVE,
   input wire logic [1:0] CH_RESET,
   input wire logic [1:0] INPUT_ERROR,
   input wire logic [15:0] MEAS_RAW,
   input wire logic VI_INPUT,
   input wire logic LIN_EN,
   input wire coc_pkg::coc_lin_t LIN_TABLE,
   input wire logic [15:0] SP_IN,
   input wire logic [15:0] RANGE_LO,
   input wire logic [15:0] RANGE_HI,
   input wire logic SP_LIM_WR,
   input wire logic [15:0] SP_LO_SET,
   input wire logic [15:0] SP_HI_SET,
   input wire logic [1:0] ACT_WR,
   input wire logic [1:0] ACT_SET,
   input wire logic [1:0] CYC_WR,
   input wire logic [6:0] CYC_SET,
   input wire coc_pkg::coc_out_cfg_t [1:0] OUT_CFG,
   input wire logic KEY_LOCKED,
   input wire logic ENTER_KEY,
   input wire logic GROUP_KEY,
   input wire logic DISPLAY_KEY,
   input wire logic COMP_WR,
   input wire logic [2:0] COMP_SEL,
   input wire logic [15:0] COMP_VAL,
   output logic FIRST_OUTPUT,
   output logic SECOND_OUTPUT,
   output logic [1:0][10:0] OUT_PCT,
   output logic [1:0] ACTION,
   output logic [1:0][6:0] CYCLE_TIME,
   output logic [15:0] MEASURED_VALUE,
   output logic [15:0] SETPOINT_VALUE,
   output logic SP_LIMIT_EXCEEDED,
   output logic COMP_SCREEN,
   output coc_pkg::coc_comp_t COMP_COUNTS,
   output logic [7:0] COMP_FACTORY
);
   import coc_pkg::*;

   coc_state_t q, d;
   logic ms_tick, sec_tick, all_rst;
   logic [1:0] rst_now, err_now;
   logic [15:0] pv_lin_c;

   // forced value in reset or error; on-off control snaps to full or zero
   function automatic logic [10:0] fixed_val(input logic [10:0] v, input logic onoff);
      logic [10:0] s;
      s = (v > PCT_FULL) ? PCT_FULL : v;
      if (onoff) begin
         s = (s >= PCT_HALF) ? PCT_FULL : PCT_ZERO;
      end
      return s;
   endfunction

   // piecewise-linear map; the division is combinational, traded for zero latency
   function automatic logic [15:0] lin_map(input logic [15:0] xin, input coc_lin_t t);
      int n;
      int seg;
      logic stop;
      logic signed [39:0] num, den, y;
      n = 0;
      seg = 0;
      stop = 1'b0;
      for (int k = 1; k < LIN_PTS; k++) begin
         if (!stop && ($signed(t.x[k]) > $signed(t.x[k-1]))) begin
            n = k; // see RULE_14
         end else begin
            stop = 1'b1;
         end
      end
      if (n == 0) begin
         return xin;
      end
      for (int k = 1; k < LIN_PTS - 1; k++) begin
         if (k < n && $signed(xin) >= $signed(t.x[k])) begin
            seg = k; // see RULE_15
         end
      end
      den = 40'($signed(t.x[seg+1])) - 40'($signed(t.x[seg]));
      num = (40'($signed(xin)) - 40'($signed(t.x[seg])))
            * (40'($signed(t.y[seg+1])) - 40'($signed(t.y[seg])));
      y = 40'($signed(t.y[seg])) + num / den;
      return y[15:0];
   endfunction

   assign rst_now = TWO_LOOP ? CH_RESET : {2{CH_RESET[0]}};
   assign err_now = TWO_LOOP ? INPUT_ERROR : {2{INPUT_ERROR[0]}};
   assign all_rst = &rst_now;
   assign ms_tick = (q.ms_div == 32'(CYC_PER_MS - 1));
   assign sec_tick = ms_tick && (q.ms_in_sec == SEC_LAST);
   assign pv_lin_c = (LIN_EN && VI_INPUT) ? lin_map(MEAS_RAW, LIN_TABLE) : MEAS_RAW; // see RULE_13

   always_comb begin
      logic signed [16:0] dev;
      logic signed [26:0] prod;
      logic [10:0] tgt, step;
      logic [9:0] rate;
      logic [16:0] period, on_ms;
      logic onoff;
      dev = '0;
      prod = '0;
      tgt = '0;
      step = '0;
      rate = '0;
      period = '0;
      on_ms = '0;
      onoff = 1'b0;
      d = q;
      d.ms_div = ms_tick ? 32'h0 : q.ms_div + 32'h1;
      if (ms_tick) begin
         d.ms_in_sec = (q.ms_in_sec == SEC_LAST) ? 10'h000 : q.ms_in_sec + 10'h001;
      end
      d.pv_lin = pv_lin_c;

      if (!q.init) begin
         // straps are caught once, the cycle after reset release
         d.init = 1'b1;
         d.act[0] = ACT_REVERSE; // see RULE_01
         d.act[1] = TWO_LOOP ? ACT_REVERSE : ACT_DIRECT; // see RULE_12
         for (int i = 0; i < N_OUT; i++) begin
            d.cyc[i] = RELAY_OUT[i] ? CYC_RELAY_DEF : CYC_SSR_DEF; // see RULE_10
         end
         d.sp_lo = RANGE_LO; // see RULE_17
         d.sp_hi = RANGE_HI;
      end else begin
         for (int i = 0; i < N_OUT; i++) begin
            if (ACT_WR[i] && !AUTO_TUNING) begin
               d.act[i] = ACT_SET[i]; // see RULE_03
            end
            if (CYC_WR[i] && !AUTO_TUNING && !RAMP_ACTIVE
                && CYC_SET >= CYC_MIN && CYC_SET <= CYC_MAX) begin
               d.cyc[i] = CYC_SET; // see RULE_11
            end
         end
         if (SP_LIM_WR && $signed(SP_LO_SET) < $signed(SP_HI_SET)
             && $signed(SP_LO_SET) >= $signed(RANGE_LO)
             && $signed(SP_HI_SET) <= $signed(RANGE_HI)) begin
            d.sp_lo = SP_LO_SET; // see RULE_17
            d.sp_hi = SP_HI_SET;
         end
      end

      // clamp setpoint to the window and flag the cut
      d.sp_over = 1'b1;
      if ($signed(SP_IN) < $signed(q.sp_lo)) begin
         d.sp_eff = q.sp_lo; // see RULE_18
      end else if ($signed(SP_IN) > $signed(q.sp_hi)) begin
         d.sp_eff = q.sp_hi;
      end else begin
         d.sp_eff = SP_IN;
         d.sp_over = 1'b0;
      end

      for (int i = 0; i < N_OUT; i++) begin
         onoff = (OUT_CFG[i].gain == 8'h00);
         if (q.act[i] == ACT_DIRECT) begin
            dev = 17'($signed(q.pv_lin)) - 17'($signed(q.sp_eff)); // see RULE_02
         end else begin
            dev = 17'($signed(q.sp_eff)) - 17'($signed(q.pv_lin)); // see RULE_01
         end
         prod = 27'(dev) * 27'($signed({1'b0, OUT_CFG[i].gain}));
         if (onoff) begin
            tgt = (dev > 17'sd0) ? PCT_FULL : PCT_ZERO;
         end else if (prod <= 27'sd0) begin
            tgt = PCT_ZERO;
         end else if (prod >= 27'($signed({16'h0, PCT_FULL}))) begin
            tgt = PCT_FULL;
         end else begin
            tgt = prod[10:0];
         end
         // reset wins over error and skips the rate limiter
         if (rst_now[i]) begin
            tgt = fixed_val(OUT_CFG[i].rst_val, onoff); // see RULE_04 RULE_05 RULE_06 RULE_09
         end else if (err_now[i]) begin
            tgt = fixed_val(OUT_CFG[i].err_val, onoff); // see RULE_07 RULE_08
         end
         rate = (OUT_CFG[i].rate > RATE_MAX) ? RATE_MAX : OUT_CFG[i].rate;
         if (rst_now[i] || rate == RATE_OFF) begin
            d.pct[i] = tgt;
         end else if (sec_tick) begin
            if (tgt > q.pct[i]) begin
               step = tgt - q.pct[i];
               step = (step > {1'b0, rate}) ? {1'b0, rate} : step;
               d.pct[i] = q.pct[i] + step; // see RULE_16 RULE_23
            end else begin
               step = q.pct[i] - tgt;
               step = (step > {1'b0, rate}) ? {1'b0, rate} : step;
               d.pct[i] = q.pct[i] - step; // see RULE_23
            end
         end
         if (i == 1 && !TWO_OUT) begin
            d.pct[i] = PCT_ZERO; // see RULE_12
         end
         period = 17'(q.cyc[i]) * MS_PER_S17;
         on_ms = 17'(q.cyc[i]) * 17'(q.pct[i]);
         if (ms_tick) begin
            d.tp_ms[i] = (q.tp_ms[i] >= period - 17'h1) ? 17'h0 : q.tp_ms[i] + 17'h1;
         end
         d.drive[i] = q.init && (q.tp_ms[i] < on_ms); // see RULE_22
      end
      // compensation screen: enter+group held, keys unlocked, all channels in reset
      case (q.cs)
         CS_IDLE: begin
            d.hold_ms = 12'h000;
            if (ENTER_KEY && GROUP_KEY && !KEY_LOCKED && all_rst) begin
               d.cs = CS_HOLD;
            end
         end
         CS_HOLD: begin
            if (!(ENTER_KEY && GROUP_KEY) || KEY_LOCKED || !all_rst) begin
               d.cs = CS_IDLE;
            end else if (ms_tick) begin
               if (q.hold_ms == HOLD_LAST) begin
                  d.cs = CS_EDIT; // see RULE_21
               end else begin
                  d.hold_ms = q.hold_ms + 12'h001;
               end
            end
         end
         CS_EDIT: begin
            if (DISPLAY_KEY || KEY_LOCKED || !all_rst) begin
               d.cs = CS_IDLE;
            end else if (COMP_WR) begin
               d.comp[COMP_SEL[2:1]][COMP_SEL[0]] = COMP_VAL; // see RULE_19 RULE_20
            end
         end
         default: begin
            d.cs = CS_IDLE;
         end
      endcase
   end

   always_ff @(posedge CLK_SYS or negedge RESET_N) begin
      if (!RESET_N) begin
         q <= ST_RESET;
      end else begin
         q <= d;
      end
   end

   assign FIRST_OUTPUT = q.drive[0];
   assign SECOND_OUTPUT = q.drive[1] && TWO_OUT;
   assign OUT_PCT = q.pct;
   assign ACTION = q.act;
   assign CYCLE_TIME = q.cyc;
   assign MEASURED_VALUE = q.pv_lin;
   assign SETPOINT_VALUE = q.sp_eff;
   assign SP_LIMIT_EXCEEDED = q.sp_over;
   assign COMP_SCREEN = (q.cs == CS_EDIT);
   assign COMP_COUNTS = q.comp;

   genvar g;
   generate
      for (g = 0; g < 8; g++) begin : g_fact
         assign COMP_FACTORY[g] = (q.comp[g/2][g%2] == 16'h0000); // see RULE_19
      end
   endgenerate

   sequence s_run0;
      q.init && !rst_now[0] && !err_now[0] && OUT_CFG[0].gain == 8'h00
         && OUT_CFG[0].rate == RATE_OFF;
   endsequence

   chk_reset_hold: assert property (@(posedge CLK_SYS) disable iff (!RESET_N) // see RULE_04
      (rst_now[0] && OUT_CFG[0].gain != 8'h00 && OUT_CFG[0].rst_val <= PCT_FULL)
      |=> OUT_PCT[0] == $past(OUT_CFG[0].rst_val)) else $error("reset value not held");
   chk_reset_onoff: assert property (@(posedge CLK_SYS) disable iff (!RESET_N) // see RULE_05
      (rst_now[0] && OUT_CFG[0].gain == 8'h00)
      |=> OUT_PCT[0] == (($past(OUT_CFG[0].rst_val) >= PCT_HALF) ? PCT_FULL : PCT_ZERO))
      else $error("on-off reset value wrong");
   chk_reset_over_err: assert property (@(posedge CLK_SYS) disable iff (!RESET_N) // see RULE_09
      (rst_now[0] && err_now[0] && OUT_CFG[0].gain != 8'h00 && OUT_CFG[0].rst_val <= PCT_FULL)
      |=> OUT_PCT[0] == $past(OUT_CFG[0].rst_val)) else $error("error beat reset");
   chk_err_onoff: assert property (@(posedge CLK_SYS) disable iff (!RESET_N) // see RULE_08
      (!rst_now[0] && err_now[0] && OUT_CFG[0].gain == 8'h00 && OUT_CFG[0].rate == RATE_OFF)
      |=> OUT_PCT[0] == (($past(OUT_CFG[0].err_val) >= PCT_HALF) ? PCT_FULL : PCT_ZERO))
      else $error("on-off error value wrong");
   chk_reverse_on: assert property (@(posedge CLK_SYS) disable iff (!RESET_N) // see RULE_01
      (s_run0 and (q.act[0] == ACT_REVERSE && $signed(q.sp_eff) > $signed(q.pv_lin)))
      |=> OUT_PCT[0] == PCT_FULL) else $error("reverse action not on");
   chk_direct_on: assert property (@(posedge CLK_SYS) disable iff (!RESET_N) // see RULE_02
      (s_run0 and (q.act[0] == ACT_DIRECT && $signed(q.pv_lin) > $signed(q.sp_eff)))
      |=> OUT_PCT[0] == PCT_FULL) else $error("direct action not on");
   chk_act_refused: assert property (@(posedge CLK_SYS) disable iff (!RESET_N) // see RULE_03
      (q.init && AUTO_TUNING && ACT_WR[0]) |=> $stable(ACTION[0]))
      else $error("action changed during tuning");
   chk_cyc_refused: assert property (@(posedge CLK_SYS) disable iff (!RESET_N) // see RULE_11
      (q.init && (AUTO_TUNING || RAMP_ACTIVE) && CYC_WR[0]) |=> $stable(CYCLE_TIME[0]))
      else $error("cycle time changed while locked");
   chk_cyc_range: assert property (@(posedge CLK_SYS) disable iff (!RESET_N) // see RULE_10
      q.init |-> (CYCLE_TIME[0] >= CYC_MIN && CYCLE_TIME[0] <= CYC_MAX))
      else $error("cycle time out of range");
   chk_sp_window: assert property (@(posedge CLK_SYS) disable iff (!RESET_N) // see RULE_18
      (q.init && $signed(SP_IN) > $signed(q.sp_hi)) |=> (SP_LIMIT_EXCEEDED
      && SETPOINT_VALUE == $past(q.sp_hi))) else $error("setpoint not clamped");
   chk_rate_step: assert property (@(posedge CLK_SYS) disable iff (!RESET_N) // see RULE_23
      (!rst_now[0] && OUT_CFG[0].rate != RATE_OFF && OUT_CFG[0].rate <= RATE_MAX)
      |=> ((OUT_PCT[0] >= $past(OUT_PCT[0]) ? OUT_PCT[0] - $past(OUT_PCT[0])
      : $past(OUT_PCT[0]) - OUT_PCT[0]) <= {1'b0, $past(OUT_CFG[0].rate)}))
      else $error("rate limit exceeded");
   chk_drive_ends: assert property (@(posedge CLK_SYS) disable iff (!RESET_N) // see RULE_22
      (q.init && OUT_PCT[0] == PCT_ZERO) |=> !FIRST_OUTPUT) else $error("drive at zero");
   chk_screen_hold: assert property (@(posedge CLK_SYS) disable iff (!RESET_N) // see RULE_21
      $rose(COMP_SCREEN) |-> $past(q.hold_ms) == HOLD_LAST) else $error("screen too early");
   chk_comp_lock: assert property (@(posedge CLK_SYS) disable iff (!RESET_N) // see RULE_20
      (COMP_WR && (KEY_LOCKED || !all_rst)) |=> $stable(COMP_COUNTS))
      else $error("compensation edited while locked");
endmodule

// ---- design/coc_pkg.sv ----
// Purpose: shared constants and types for the control output conditioner
// Assumes: percentages in tenths of a percent, 125 MHz system clock
// Notes: all times are derived from a millisecond tick
package coc_pkg;
   localparam int N_OUT = 2;
   localparam int LIN_PTS = 11;
   localparam logic [10:0] PCT_ZERO = 11'h000;
   localparam logic [10:0] PCT_HALF = 11'h1F4;
   localparam logic [10:0] PCT_FULL = 11'h3E8;
   localparam logic [6:0] CYC_MIN = 7'h01;
   localparam logic [6:0] CYC_MAX = 7'h78;
   localparam logic [6:0] CYC_RELAY_DEF = 7'h1E;
   localparam logic [6:0] CYC_SSR_DEF = 7'h03;
   localparam logic [9:0] RATE_OFF = 10'h000;
   localparam logic [9:0] RATE_MAX = 10'h3E8;
   localparam int CLK_HZ = 125000000;
   localparam int MS_PER_S = 1000;
   localparam int CYC_PER_MS_DEF = CLK_HZ / MS_PER_S;
   localparam int KEY_HOLD_S = 3;
   localparam int KEY_HOLD_MS = KEY_HOLD_S * MS_PER_S;
   localparam logic [11:0] HOLD_LAST = 12'(KEY_HOLD_MS - 1);
   localparam logic [9:0] SEC_LAST = 10'(MS_PER_S - 1);
   localparam logic [16:0] MS_PER_S17 = 17'(MS_PER_S);

   typedef enum logic {ACT_REVERSE = 1'b0, ACT_DIRECT = 1'b1} coc_act_t;
   typedef enum logic [1:0] {CS_IDLE = 2'b00, CS_HOLD = 2'b01, CS_EDIT = 2'b10} coc_cs_t;

   typedef struct packed {
      logic [10:0] rst_val;
      logic [10:0] err_val;
      logic [7:0] gain;
      logic [9:0] rate;
   } coc_out_cfg_t;

   typedef struct packed {
      logic [LIN_PTS-1:0][15:0] x;
      logic [LIN_PTS-1:0][15:0] y;
   } coc_lin_t;

   typedef logic [3:0][1:0][15:0] coc_comp_t;

   typedef struct packed {
      logic init;
      logic [31:0] ms_div;
      logic [9:0] ms_in_sec;
      logic [1:0] act;
      logic [1:0][6:0] cyc;
      logic [1:0][16:0] tp_ms;
      logic [1:0][10:0] pct;
      logic [1:0] drive;
      logic [15:0] pv_lin;
      logic [15:0] sp_lo;
      logic [15:0] sp_hi;
      logic [15:0] sp_eff;
      logic sp_over;
      coc_cs_t cs;
      logic [11:0] hold_ms;
      coc_comp_t comp;
   } coc_state_t;

   localparam coc_state_t ST_RESET = '0;
endpackage

// ---- dv/coc_actuator.sv ----
// Purpose: load stand-in that measures on-time of a time-proportioned drive
// Assumes: window length equals one proportional cycle in clocks
// Notes: count refreshed at each window end, so any phase of the cycle gives the same total
`timescale 1ns/100ps
module coc_actuator #(
   parameter int WIN = 4000
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic drive,
   output logic [15:0] on_cnt
);
   logic [15:0] pos_q;
   logic [15:0] acc_q;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pos_q <= 16'h0000;
         acc_q <= 16'h0000;
         on_cnt <= 16'h0000;
      end else if (pos_q == 16'(WIN - 1)) begin
         pos_q <= 16'h0000;
         acc_q <= 16'h0000;
         on_cnt <= acc_q + 16'(drive);
      end else begin
         pos_q <= pos_q + 16'h0001;
         acc_q <= acc_q + 16'(drive);
      end
   end
endmodule

// ---- dv/coc_top_tb.sv ----
// Purpose: self-checking bench for the control output conditioner
// Assumes: CYC_PER_MS of 4, so one second is 4000 clocks
// Notes: inputs change on the falling edge only
`timescale 1ns/100ps
module coc_top_tb;
   import coc_pkg::*;
   logic clk, rst_n, two_out, two_loop, at, ramp, vi, lin_en, sp_wr, locked, enter_key, group_key, display_key;
   logic comp_wr, first_output, second_output, sp_exc, scr;
   logic [1:0] relay, ch_rst, in_err, act_wr, act_set, cyc_wr, act;
   logic [15:0] meas, sp_in, rng_lo, rng_hi, sp_lo, sp_hi, comp_val, mv, spv, on1, on2;
   logic [6:0] cyc_set;
   logic [2:0] comp_sel;
   logic [1:0][10:0] pct;
   logic [1:0][6:0] cyc;
   logic [7:0] fac;
   coc_lin_t lin;
   coc_out_cfg_t [1:0] cfg;
   coc_comp_t cnt;
   int n_fail, tests_run;

   coc_top #(.CYC_PER_MS(4)) dut_u (.CLK_SYS(clk), .RESET_N(rst_n), .TWO_OUT(two_out),
      .TWO_LOOP(two_loop), .RELAY_OUT(relay), .AUTO_TUNING(at), .RAMP_ACTIVE(ramp),
      .CH_RESET(ch_rst), .INPUT_ERROR(in_err), .MEAS_RAW(meas), .VI_INPUT(vi),
      .LIN_EN(lin_en), .LIN_TABLE(lin), .SP_IN(sp_in), .RANGE_LO(rng_lo), .RANGE_HI(rng_hi),
      .SP_LIM_WR(sp_wr), .SP_LO_SET(sp_lo), .SP_HI_SET(sp_hi), .ACT_WR(act_wr),
      .ACT_SET(act_set), .CYC_WR(cyc_wr), .CYC_SET(cyc_set), .OUT_CFG(cfg),
      .KEY_LOCKED(locked), .ENTER_KEY(enter_key), .GROUP_KEY(group_key), .DISPLAY_KEY(display_key),
      .COMP_WR(comp_wr), .COMP_SEL(comp_sel), .COMP_VAL(comp_val), .FIRST_OUTPUT(first_output),
      .SECOND_OUTPUT(second_output), .OUT_PCT(pct), .ACTION(act), .CYCLE_TIME(cyc),
      .MEASURED_VALUE(mv), .SETPOINT_VALUE(spv), .SP_LIMIT_EXCEEDED(sp_exc),
      .COMP_SCREEN(scr), .COMP_COUNTS(cnt), .COMP_FACTORY(fac));
   coc_actuator #(.WIN(4000)) load1_u (.clk(clk), .rst_n(rst_n), .drive(first_output), .on_cnt(on1));
   coc_actuator #(.WIN(4000)) load2_u (.clk(clk), .rst_n(rst_n), .drive(second_output), .on_cnt(on2));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task automatic test_done();
      if (n_fail == 0 && tests_run > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask

   task automatic wr_act(input logic [1:0] m, input logic [1:0] v);
      act_wr = m;
      act_set = v;
      tick(1);
      act_wr = 2'h0;
      tick(2);
   endtask

   task automatic wr_cyc(input logic [6:0] v);
      cyc_wr = 2'h3;
      cyc_set = v;
      tick(1);
      cyc_wr = 2'h0;
      tick(2);
   endtask

   task automatic wr_sp(input logic [15:0] lo, input logic [15:0] hi);
      sp_wr = 1'b1;
      sp_lo = lo;
      sp_hi = hi;
      tick(1);
      sp_wr = 1'b0;
      tick(4);
   endtask

   task automatic wr_comp(input logic [2:0] s, input logic [15:0] v);
      comp_wr = 1'b1;
      comp_sel = s;
      comp_val = v;
      tick(1);
      comp_wr = 1'b0;
      tick(2);
   endtask

   // rate limiter steps once a second; wait a little over one step
   task automatic wait_chg(input logic [15:0] exp);
      logic [10:0] old;
      int i;
      old = pct[0];
      i = 0;
      while (pct[0] === old && i < 4200) begin
         tick(1);
         i++;
      end
      chk(16'(pct[0]), exp);
   endtask

   task automatic dp(input logic [15:0] pv, input logic [15:0] sp, input logic [15:0] exp);
      meas = pv;
      sp_in = sp;
      tick(4);
      chk(16'(pct[0]), exp);
   endtask

   initial begin
      #480000;
      n_fail++;
      test_done();
   end

   initial begin
      n_fail = 0;
      tests_run = 0;
      rst_n = 1'b0;
      {two_out, two_loop, at, ramp, vi, lin_en, sp_wr, locked, enter_key, group_key, display_key, comp_wr} = '0;
      relay = 2'h1;
      ch_rst = 2'h0;
      in_err = 2'h0;
      act_wr = 2'h0;
      act_set = 2'h0;
      cyc_wr = 2'h0;
      cyc_set = 7'h00;
      meas = 16'h0000;
      sp_in = 16'h0000;
      rng_lo = 16'hFC18;
      rng_hi = 16'h07D0;
      sp_lo = 16'h0000;
      sp_hi = 16'h0000;
      comp_sel = 3'h0;
      comp_val = 16'h0000;
      lin = '0;
      cfg = '0;
      two_out = 1'b1;
      tick(5);
      rst_n = 1'b1;
      tick(3);
      chk(16'(act), 16'h0002);
      chk(16'(cyc[0]), 16'(CYC_RELAY_DEF));
      chk(16'(cyc[1]), 16'(CYC_SSR_DEF));
      at = 1'b1;
      wr_act(2'h1, 2'h1);
      chk(16'(act[0]), 16'h0000);
      wr_cyc(7'h05);
      chk(16'(cyc[0]), 16'(CYC_RELAY_DEF));
      at = 1'b0;
      ramp = 1'b1;
      wr_cyc(7'h05);
      chk(16'(cyc[1]), 16'(CYC_SSR_DEF));
      ramp = 1'b0;
      wr_cyc(7'h00);
      wr_cyc(7'h79);
      chk(16'(cyc[0]), 16'(CYC_RELAY_DEF));
      wr_cyc(CYC_MAX);
      chk(16'(cyc[1]), 16'h0078);
      cfg[0].gain = 8'h0A;
      cfg[1].gain = 8'h0A;
      dp(16'h0032, 16'h0064, 16'h01F4);
      wr_act(2'h1, 2'h1);
      chk(16'(act[0]), 16'h0001);
      dp(16'h0032, 16'h0064, 16'h0000);
      dp(16'h0096, 16'h0064, 16'h01F4);
      cfg[0].rst_val = 11'h12C;
      cfg[1].rst_val = 11'h0C8;
      cfg[0].err_val = 11'h2BC;
      cfg[1].err_val = 11'h2BC;
      ch_rst = 2'h1;
      dp(16'h0096, 16'h0064, 16'h012C);
      chk(16'(pct[1]), 16'h00C8);
      in_err = 2'h1;
      dp(16'h0096, 16'h0064, 16'h012C);
      ch_rst = 2'h0;
      dp(16'h0096, 16'h0064, 16'h02BC);
      chk(16'(pct[1]), 16'h02BC);
      cfg[0].gain = 8'h00;
      cfg[0].err_val = PCT_HALF;
      dp(16'h0096, 16'h0064, 16'h03E8);
      cfg[0].err_val = 11'h1F3;
      dp(16'h0096, 16'h0064, 16'h0000);
      in_err = 2'h0;
      dp(16'h0096, 16'h0064, 16'h03E8);
      in_err = 2'h1;
      ch_rst = 2'h1;
      dp(16'h0096, 16'h0064, 16'h0000);
      cfg[0].rst_val = PCT_HALF;
      dp(16'h0096, 16'h0064, 16'h03E8);
      in_err = 2'h0;
      chk(mv, 16'h0096);
      chk(spv, 16'h0064);
      wr_sp(16'h0000, 16'h00C8);
      dp(16'h0000, 16'h012C, 16'h03E8);
      chk(spv, 16'h00C8);
      chk(16'(sp_exc), 16'h0001);
      wr_sp(16'h00C8, 16'h00C8);
      wr_sp(16'h0000, 16'h0BB8);
      chk(spv, 16'h00C8);
      sp_in = 16'hFFCE;
      tick(3);
      chk(spv, 16'h0000);
      sp_in = 16'h0064;
      tick(3);
      chk(16'(sp_exc), 16'h0000);
      // fourth point steps back, so only two segments remain
      lin.x[1] = 16'h0064;
      lin.x[2] = 16'h00C8;
      lin.x[3] = 16'h0096;
      lin.y[1] = 16'h03E8;
      lin.y[2] = 16'h04B0;
      lin.y[3] = 16'h7000;
      lin_en = 1'b1;
      meas = 16'h012C;
      tick(3);
      chk(mv, 16'h012C);
      vi = 1'b1;
      tick(3);
      chk(mv, 16'h0578);
      meas = 16'h0032;
      tick(3);
      chk(mv, 16'h01F4);
      meas = 16'hFFCE;
      tick(3);
      chk(mv, 16'hFE0C);
      wr_cyc(CYC_MIN);
      cfg[0].gain = 8'h0A;
      cfg[0].rst_val = 11'h0FA;
      cfg[1].rst_val = PCT_HALF;
      tick(12000);
      chk(on1, 16'h03E8);
      chk(on2, 16'h07D0);
      ch_rst = 2'h3;
      wr_comp(3'h1, 16'h0005);
      chk(cnt[0][1], 16'h0000);
      locked = 1'b1;
      enter_key = 1'b1;
      group_key = 1'b1;
      tick(40);
      chk(16'(scr), 16'h0000);
      locked = 1'b0;
      tick(11990);
      chk(16'(scr), 16'h0000);
      tick(20);
      chk(16'(scr), 16'h0001);
      enter_key = 1'b0;
      group_key = 1'b0;
      wr_comp(3'h1, 16'h0005);
      chk(cnt[0][1], 16'h0005);
      chk(16'(fac[1]), 16'h0000);
      wr_comp(3'h6, 16'h0007);
      chk(cnt[3][0], 16'h0007);
      wr_comp(3'h1, 16'h0000);
      chk(16'(fac[1]), 16'h0001);
      display_key = 1'b1;
      tick(3);
      chk(16'(scr), 16'h0000);
      display_key = 1'b0;
      cfg[0].rst_val = PCT_ZERO;
      cfg[0].err_val = PCT_FULL;
      cfg[0].rate = 10'h064;
      tick(4);
      chk(16'(pct[0]), 16'h0000);
      ch_rst = 2'h0;
      in_err = 2'h1;
      wait_chg(16'h0064);
      wait_chg(16'h00C8);
      cfg[0].err_val = PCT_ZERO;
      wait_chg(16'h0064);
      // second reset: two-loop defaults, SSR/relay swapped, second output absent
      two_out = 1'b0;
      two_loop = 1'b1;
      relay = 2'h2;
      ch_rst = 2'h2;
      in_err = 2'h0;
      cfg[0].gain = 8'h00;
      cfg[0].rate = RATE_OFF;
      rst_n = 1'b0;
      tick(5);
      rst_n = 1'b1;
      tick(3);
      chk(16'(act), 16'h0000);
      chk(16'(cyc[0]), 16'(CYC_SSR_DEF));
      chk(16'(cyc[1]), 16'(CYC_RELAY_DEF));
      chk(16'(pct[1]), 16'h0000);
      dp(16'hFFCE, 16'h0064, 16'h03E8);
      test_done();
   end
endmodule
